// ### logic/smc_pkg.sv
`default_nettype none
package smc_pkg;
    // sleep mode select codes
    localparam logic [2:0] SEL_IDLE = 3'h0;
    localparam logic [2:0] SEL_ADCNR = 3'h1;
    localparam logic [2:0] SEL_PWR_DOWN = 3'h2;
    localparam logic [2:0] SEL_PWR_SAVE = 3'h3;
    localparam logic [2:0] SEL_STANDBY = 3'h6;
    localparam logic [2:0] SEL_EXT_STANDBY = 3'h7;

    // control register field positions and reset value
    localparam int DSO_BIT = 6;
    localparam int UNLOCK_BIT = 5;
    localparam logic [7:0] MCU_CTRL_RESET = 8'h00;

    // timed unlock sequence, in cycles
    localparam logic [2:0] UNLOCK_WINDOW = 3'h4;
    localparam logic [2:0] DSO_DELAY = 3'h3;
    localparam logic [2:0] DSO_HOLD = 3'h3;
    localparam logic [2:0] DSO_TOTAL = 3'(DSO_DELAY + DSO_HOLD);

    // wake-up timing
    localparam int CLK_MHZ = 40;
    localparam int BOD_WAKE_US = 60;
    localparam logic [15:0] BOD_WAKE_CYC = 16'(BOD_WAKE_US * CLK_MHZ);
    localparam logic [15:0] STANDBY_WAKE_CYC = 16'h0006;
    localparam logic [15:0] IRQ_HALT_CYC = 16'h0004;
    localparam logic [15:0] NO_WAIT_CYC = 16'h0000;

    // oscillator start-up counts per clock select fuse code
    localparam logic [15:0] STARTUP_CYC0 = 16'h0006;
    localparam logic [15:0] STARTUP_CYC1 = 16'h0102;
    localparam logic [15:0] STARTUP_CYC2 = 16'h0400;
    localparam logic [15:0] STARTUP_CYC3 = 16'h1000;

    localparam int PERIPH_COUNT = 8;

    typedef enum logic [2:0] {
        MODE_IDLE, MODE_ADCNR, MODE_PWR_DOWN, MODE_PWR_SAVE, MODE_STANDBY, MODE_EXT_STANDBY
    } smc_mode_t;

    typedef enum logic [1:0] {
        ST_ACTIVE, ST_SLEEP, ST_STARTUP, ST_HALT
    } smc_state_t;

    typedef struct packed {
        logic [2:0] sleep_mode_select;
        logic sleep_enable_bit;
    } smc_sleep_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } smc_mcu_wr_t;

    typedef struct packed {
        logic enabled;
        logic async;
    } smc_t2_cfg_t;

    // wake sources; interrupts other than timer two arrive already qualified by their enables
    typedef struct packed {
        logic ext_reset;
        logic wdt_reset;
        logic bor_reset;
        logic wdt_irq;
        logic twi_addr_match;
        logic twi_irq;
        logic low_ext_irq;
        logic high_ext_level_irq;
        logic pin_change;
        logic timer2_ovf;
        logic timer2_cmp;
        logic adc_done;
        logic spm_ready;
        logic other_io_irq;
    } smc_wake_t;

    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_osc;
        logic timer_osc;
        logic timer2_sync;
    } smc_clk_en_t;
endpackage
`default_nettype wire

// ### logic/smc_wake_timer.sv
`default_nettype none
module smc_wake_timer (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [15:0] value_in,
    output logic done_out
);
    import smc_pkg::*;

    typedef struct packed {
        logic busy;
        logic [15:0] cnt;
    } smc_tmr_state_t;

    smc_tmr_state_t cur;
    smc_tmr_state_t next_cur;

    // done in the cycle the count reaches one
    assign done_out = cur.busy && (cur.cnt == 16'h0001);

    // down counter, reload restarts it
    always_comb begin
        next_cur = cur;
        if (load_in) begin
            next_cur.busy = (value_in != 16'h0000);
            next_cur.cnt = value_in;
        end else if (cur.busy) begin
            next_cur.cnt = cur.cnt - 16'h0001;
            if (cur.cnt == 16'h0001) begin
                next_cur.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
endmodule
`default_nettype wire

// ### logic/smc_dso_unlock.sv
`default_nettype none
module smc_dso_unlock (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire smc_pkg::smc_mcu_wr_t mcu_wr_in,
    output logic detector_sleep_off_out,
    output logic detector_sleep_unlock_out,
    output logic dso_active_out
);
    import smc_pkg::*;

    typedef struct packed {
        logic dso;
        logic unlock;
        logic [2:0] unlock_cnt;
        logic [2:0] dso_cnt;
    } smc_unl_state_t;

    smc_unl_state_t cur;
    smc_unl_state_t next_cur;

    assign detector_sleep_off_out = cur.dso;
    assign detector_sleep_unlock_out = cur.unlock;
    // effective only after the set delay, until self clear
    assign dso_active_out = cur.dso && (cur.dso_cnt <= DSO_HOLD) && (cur.dso_cnt != 3'h0); // R24

    // unlock window and self-clearing sleep-off bit
    always_comb begin
        next_cur = cur;
        if (cur.unlock) begin
            next_cur.unlock_cnt = cur.unlock_cnt - 3'h1; // R23
            if (cur.unlock_cnt == 3'h1) begin
                next_cur.unlock = 1'b0;
            end
        end
        if (cur.dso) begin
            next_cur.dso_cnt = cur.dso_cnt - 3'h1; // R24
            if (cur.dso_cnt == 3'h1) begin
                next_cur.dso = 1'b0;
            end
        end
        if (mcu_wr_in.valid && mcu_wr_in.data[DSO_BIT]) begin
            if (mcu_wr_in.data[UNLOCK_BIT]) begin
                // rewriting inside the window does not extend it
                if (!cur.unlock) begin
                    next_cur.unlock = 1'b1; // R4
                    next_cur.unlock_cnt = UNLOCK_WINDOW; // R23
                end
            end else if (cur.unlock) begin
                next_cur.dso = 1'b1; // R4
                next_cur.dso_cnt = DSO_TOTAL; // R24
                next_cur.unlock = 1'b0;
                next_cur.unlock_cnt = 3'h0;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cur <= '0; // R3
        end else begin
            cur <= next_cur;
        end
    end
endmodule
`default_nettype wire

// ### logic/smc_sleep_ctrl.sv
// How it works
// R1: with sleep-off armed, detector goes off on sleep entry, on again at wake; code does so only in power-down, power-save and the two standby modes.
// R2: after a sleep with detector off, wake delay is stretched to 60 us.
// R3: detector-sleep-off bit sits at control bit 6, resets to zero.
// R4: detector-sleep-off bit only accepts writes through the timed unlock.
// R5: select 000 enters idle: CPU and flash clocks stop, others run.
// R6: idle wakes on any interrupt; idle and ADC mode start enabled ADC.
// R7: select 001 enters ADC mode: I/O, CPU, flash clocks stop.
// R8: ADC mode wakes only on its listed reset and interrupt sources.
// R9: select 010 enters power-down: oscillator and all generated clocks stop.
// R10: power-down wakes on resets, address match, low lines, pin change.
// R11: external agent holds a level wake interrupt long enough.
// R12: power-down wake waits the start-up time chosen by clock fuses.
// R13: select 011 enters power-save: power-down plus running timer two.
// R14: timer two wakes power-save only with its mask and global enable.
// R15: power-save keeps timer oscillator or main clock only as timer two needs.
// R16: software prefers power-down when timer two is idle.
// R17: select 110 with crystal enters standby, oscillator on, six-cycle wake.
// R18: select 111 with crystal enters extended standby, six-cycle wake.
// R19: power-reduction bit stops a peripheral clock and blocks its registers.
// R20: clearing the bit restarts the clock with state intact.
// R21: software disables a peripheral before stopping its clock.
// R22: per-peripheral stopping acts in active and idle only.
// R23: unlock writes both bits one, then within four cycles sleep-off alone.
// R24: sleep-off effective three cycles after set, clears three cycles later.
// R25: sleep instruction sleeps only while sleep enable is set.
// R26: interrupt wake holds the CPU four cycles beyond start-up.
// R27: reserved codes or standby without crystal fall back to idle.
`default_nettype none
module smc_sleep_ctrl (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic sleep_instr_in,
    input wire smc_pkg::smc_sleep_ctrl_t sleep_ctrl_in,
    input wire smc_pkg::smc_mcu_wr_t mcu_wr_in,
    input wire logic crystal_clock_in,
    input wire logic [1:0] clock_select_fuses_in,
    input wire smc_pkg::smc_wake_t wake_in,
    input wire logic [1:0] timer_two_irq_mask_in,
    input wire logic global_irq_enable_in,
    input wire smc_pkg::smc_t2_cfg_t timer2_cfg_in,
    input wire logic adc_enabled_in,
    input wire logic [7:0] power_reduction_reg_in,
    output smc_pkg::smc_clk_en_t clk_en_out,
    output logic [7:0] periph_clk_en_out,
    output logic [7:0] periph_access_en_out,
    output logic bod_enable_out,
    output logic adc_start_out,
    output logic cpu_halt_out,
    output smc_pkg::smc_state_t sleep_state_out,
    output smc_pkg::smc_mode_t sleep_mode_out,
    output logic wake_event_out,
    output logic wake_by_reset_out,
    output logic [7:0] mcu_control_reg_out
);
    import smc_pkg::*;

    typedef struct packed {
        smc_state_t state;
        smc_mode_t mode;
        logic bod_off;
        logic bod_en;
        logic wake_irq;
        logic adc_start;
        logic wake_event;
        logic wake_reset;
        smc_clk_en_t clk;
        logic [7:0] periph_clk;
        logic [7:0] periph_access;
    } smc_ctrl_state_t;

    smc_ctrl_state_t cur;
    smc_ctrl_state_t next_cur;

    logic dso_bit;
    logic unlock_bit;
    logic dso_active;
    logic timer_load;
    logic [15:0] timer_value;
    logic timer_done;
    smc_mode_t req_mode;
    logic wake_any;
    logic wake_reset;
    logic t2_wake;
    logic [15:0] startup_cyc;
    logic [15:0] wake_delay;
    smc_mode_t clk_mode;
    smc_clk_en_t mode_clk;
    logic [7:0] next_periph_access;

    // timed unlock of the detector sleep-off bit
    smc_dso_unlock u_unlock (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .mcu_wr_in(mcu_wr_in),
        .detector_sleep_off_out(dso_bit),
        .detector_sleep_unlock_out(unlock_bit),
        .dso_active_out(dso_active)
    );

    // start-up and halt counter shared by the wake phases
    smc_wake_timer u_timer (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .load_in(timer_load),
        .value_in(timer_value),
        .done_out(timer_done)
    );

    // register outputs
    assign clk_en_out = cur.clk;
    assign periph_clk_en_out = cur.periph_clk;
    assign periph_access_en_out = cur.periph_access;
    assign bod_enable_out = cur.bod_en;
    assign adc_start_out = cur.adc_start;
    assign cpu_halt_out = !cur.clk.cpu;
    assign sleep_state_out = cur.state;
    assign sleep_mode_out = cur.mode;
    assign wake_event_out = cur.wake_event;
    assign wake_by_reset_out = cur.wake_reset;

    // control register read view
    always_comb begin
        mcu_control_reg_out = MCU_CTRL_RESET;
        mcu_control_reg_out[DSO_BIT] = dso_bit; // R3
        mcu_control_reg_out[UNLOCK_BIT] = unlock_bit;
    end

    // mode select decode with safe fallback
    always_comb begin
        unique case (sleep_ctrl_in.sleep_mode_select)
            SEL_IDLE: req_mode = MODE_IDLE; // R5
            SEL_ADCNR: req_mode = MODE_ADCNR; // R7
            SEL_PWR_DOWN: req_mode = MODE_PWR_DOWN; // R9
            SEL_PWR_SAVE: req_mode = MODE_PWR_SAVE; // R13
            SEL_STANDBY: req_mode = crystal_clock_in ? MODE_STANDBY : MODE_IDLE; // R17
            SEL_EXT_STANDBY: req_mode = crystal_clock_in ? MODE_EXT_STANDBY : MODE_IDLE; // R18
            default: req_mode = MODE_IDLE; // R27
        endcase
    end

    // timer two wake needs its own mask and the global enable
    assign t2_wake = global_irq_enable_in && timer2_cfg_in.enabled
        && ((wake_in.timer2_ovf && timer_two_irq_mask_in[0])
        || (wake_in.timer2_cmp && timer_two_irq_mask_in[1])); // R14
    assign wake_reset = wake_in.ext_reset || wake_in.wdt_reset || wake_in.bor_reset;

    // wake source qualification per mode
    always_comb begin
        wake_any = 1'b0;
        unique case (cur.mode)
            MODE_IDLE: begin
                // any interrupt or reset wakes idle
                wake_any = wake_reset || (|wake_in[10:0]); // R6
            end
            MODE_ADCNR: begin
                wake_any = wake_reset || wake_in.adc_done || wake_in.wdt_irq
                    || wake_in.twi_irq || wake_in.twi_addr_match
                    || wake_in.timer2_ovf || wake_in.timer2_cmp
                    || wake_in.spm_ready || wake_in.high_ext_level_irq
                    || wake_in.pin_change; // R8
            end
            MODE_PWR_DOWN, MODE_STANDBY: begin
                wake_any = wake_reset || wake_in.twi_addr_match
                    || wake_in.low_ext_irq || wake_in.pin_change; // R10
            end
            MODE_PWR_SAVE, MODE_EXT_STANDBY: begin
                wake_any = wake_reset || wake_in.twi_addr_match
                    || wake_in.low_ext_irq || wake_in.pin_change || t2_wake; // R13
            end
        endcase
    end

    // oscillator start-up count from clock select fuses
    always_comb begin
        unique case (clock_select_fuses_in)
            2'h0: startup_cyc = STARTUP_CYC0;
            2'h1: startup_cyc = STARTUP_CYC1;
            2'h2: startup_cyc = STARTUP_CYC2;
            2'h3: startup_cyc = STARTUP_CYC3;
        endcase
    end

    // wake delay by mode, stretched when the detector was off
    always_comb begin
        wake_delay = NO_WAIT_CYC;
        unique case (cur.mode)
            MODE_IDLE, MODE_ADCNR: wake_delay = NO_WAIT_CYC;
            MODE_PWR_DOWN, MODE_PWR_SAVE: wake_delay = startup_cyc; // R12
            MODE_STANDBY, MODE_EXT_STANDBY: wake_delay = STANDBY_WAKE_CYC; // R17 R18
        endcase
        // detector must settle before code runs
        if (cur.bod_off && (wake_delay < BOD_WAKE_CYC)) begin
            wake_delay = BOD_WAKE_CYC; // R2
        end
    end

    // mode being entered, or the one being held
    assign clk_mode = (cur.state == ST_ACTIVE) ? req_mode : cur.mode;

    // clock domains kept running in each sleep mode
    always_comb begin
        mode_clk = '0;
        unique case (clk_mode)
            MODE_IDLE: begin
                mode_clk.io = 1'b1; // R5
                mode_clk.adc = 1'b1;
                mode_clk.asy = 1'b1;
                mode_clk.main_osc = 1'b1;
                mode_clk.timer2_sync = 1'b1;
                mode_clk.timer_osc = timer2_cfg_in.async;
            end
            MODE_ADCNR: begin
                mode_clk.adc = 1'b1; // R7
                mode_clk.asy = 1'b1;
                mode_clk.main_osc = 1'b1;
                mode_clk.timer_osc = timer2_cfg_in.async;
            end
            MODE_PWR_DOWN: begin
                mode_clk = '0; // R9
            end
            MODE_PWR_SAVE: begin
                mode_clk.asy = timer2_cfg_in.enabled && timer2_cfg_in.async;
                mode_clk.timer_osc = timer2_cfg_in.enabled && timer2_cfg_in.async; // R15
                mode_clk.main_osc = timer2_cfg_in.enabled && !timer2_cfg_in.async; // R15
                mode_clk.timer2_sync = mode_clk.main_osc; // R15
            end
            MODE_STANDBY: begin
                mode_clk.main_osc = 1'b1; // R17
            end
            MODE_EXT_STANDBY: begin
                mode_clk.main_osc = 1'b1; // R18
                mode_clk.asy = timer2_cfg_in.enabled && timer2_cfg_in.async;
                mode_clk.timer_osc = timer2_cfg_in.enabled && timer2_cfg_in.async;
                mode_clk.timer2_sync = timer2_cfg_in.enabled && !timer2_cfg_in.async;
            end
        endcase
    end

    // per-peripheral clock and register access gating
    for (genvar i = 0; i < PERIPH_COUNT; i++) begin : g_periph
        assign next_periph_access[i] = !power_reduction_reg_in[i]; // R19 R20
    end

    // sleep state machine
    always_comb begin
        next_cur = cur;
        next_cur.adc_start = 1'b0;
        next_cur.wake_event = 1'b0;
        next_cur.wake_reset = 1'b0;
        timer_load = 1'b0;
        timer_value = NO_WAIT_CYC;
        unique case (cur.state)
            ST_ACTIVE: begin
                // running, all clocks on, timer oscillator only when timer two is async
                next_cur.clk = '1;
                next_cur.clk.timer_osc = timer2_cfg_in.async;
                next_cur.bod_en = 1'b1;
                if (sleep_instr_in && sleep_ctrl_in.sleep_enable_bit) begin // R25
                    next_cur.state = ST_SLEEP;
                    next_cur.mode = req_mode;
                    next_cur.clk = mode_clk; // R5 R7 R9
                    // sleep-off honoured only in modes that allow it
                    next_cur.bod_off = dso_active
                        && (req_mode != MODE_IDLE) && (req_mode != MODE_ADCNR); // R1 R24
                    next_cur.adc_start = adc_enabled_in
                        && ((req_mode == MODE_IDLE) || (req_mode == MODE_ADCNR)); // R6
                end
            end
            ST_SLEEP: begin
                // mode clocks until a qualified wake
                next_cur.clk = mode_clk;
                next_cur.bod_en = !cur.bod_off; // R1
                if (wake_any) begin
                    next_cur.wake_event = 1'b1;
                    next_cur.wake_irq = !wake_reset;
                    next_cur.bod_en = 1'b1; // R1
                    next_cur.clk.main_osc = 1'b1;
                    if (wake_delay == NO_WAIT_CYC) begin
                        next_cur.state = ST_HALT;
                        timer_load = 1'b1;
                        timer_value = wake_reset ? 16'h0001 : IRQ_HALT_CYC; // R26
                    end else begin
                        next_cur.state = ST_STARTUP;
                        timer_load = 1'b1;
                        timer_value = wake_delay; // R2 R12
                    end
                end
            end
            ST_STARTUP: begin
                // oscillator restarting, generated clocks still held
                next_cur.bod_en = 1'b1;
                if (timer_done) begin
                    next_cur.state = ST_HALT;
                    next_cur.bod_off = 1'b0;
                    next_cur.clk = '1;
                    next_cur.clk.cpu = 1'b0;
                    next_cur.clk.flash = 1'b0;
                    next_cur.clk.timer_osc = timer2_cfg_in.async;
                    timer_load = 1'b1;
                    timer_value = cur.wake_irq ? IRQ_HALT_CYC : 16'h0001; // R26
                end
            end
            ST_HALT: begin
                // cpu held after start-up
                next_cur.bod_off = 1'b0;
                next_cur.bod_en = 1'b1;
                next_cur.clk = '1;
                next_cur.clk.cpu = 1'b0;
                next_cur.clk.flash = 1'b0;
                next_cur.clk.timer_osc = timer2_cfg_in.async;
                if (timer_done) begin
                    next_cur.state = ST_ACTIVE;
                    next_cur.clk.cpu = 1'b1; // R26
                    next_cur.clk.flash = 1'b1;
                    next_cur.wake_reset = !cur.wake_irq;
                    next_cur.wake_irq = 1'b0;
                end
            end
        endcase
        next_cur.periph_clk = next_cur.clk.io ? next_periph_access : 8'h00; // R19 R22
        next_cur.periph_access = next_periph_access;
    end

    // state register
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cur <= '0;
            cur.state <= ST_ACTIVE;
            cur.mode <= MODE_IDLE;
            cur.bod_en <= 1'b1;
            cur.clk <= '1;
            cur.periph_clk <= '1;
            cur.periph_access <= '1;
        end else begin
            cur <= next_cur;
        end
    end
endmodule
`default_nettype wire

// ### tb/smc_sleep_ctrl_asserts.sv
`default_nettype none
module smc_sleep_ctrl_asserts
    import smc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic sleep_instr_in,
    input wire smc_pkg::smc_sleep_ctrl_t sleep_ctrl_in,
    input wire smc_pkg::smc_mcu_wr_t mcu_wr_in,
    input wire logic [7:0] power_reduction_reg_in,
    input wire smc_pkg::smc_clk_en_t clk_en_out,
    input wire logic [7:0] periph_access_en_out,
    input wire logic bod_enable_out,
    input wire smc_pkg::smc_state_t sleep_state_out,
    input wire smc_pkg::smc_mode_t sleep_mode_out,
    input wire logic [7:0] mcu_control_reg_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    logic act;
    logic slp;
    // state shorthands
    assign act = sleep_state_out == ST_ACTIVE;
    assign slp = sleep_state_out == ST_SLEEP;
    // multi-step behaviours
    sequence dso_held;
        mcu_control_reg_out[6] [*6];
    endsequence
    sequence boot_six;
        (sleep_state_out == ST_STARTUP) [*6];
    endsequence
    reg_reset_a: assert property (disable iff (1'b0) rst_in |=> mcu_control_reg_out == 8'h00 && bod_enable_out) else $error("reset values wrong");
    sleep_entry_a: assert property (sleep_instr_in && sleep_ctrl_in.sleep_enable_bit && act |=> slp) else $error("sleep not entered");
    no_sleep_a: assert property (sleep_instr_in && !sleep_ctrl_in.sleep_enable_bit && act |=> act) else $error("slept without enable");
    idle_clk_a: assert property (slp && sleep_mode_out == MODE_IDLE |-> !clk_en_out.cpu && !clk_en_out.flash && clk_en_out.io && clk_en_out.adc) else $error("idle clocks wrong");
    pd_clk_a: assert property (slp && sleep_mode_out == MODE_PWR_DOWN |-> !clk_en_out.main_osc && !clk_en_out.io && !clk_en_out.adc && !clk_en_out.asy) else $error("power-down clocks wrong");
    unlock_set_a: assert property (mcu_wr_in.valid && mcu_wr_in.data[6:5] == 2'b11 && !mcu_control_reg_out[5] |=> mcu_control_reg_out[5]) else $error("unlock not set");
    refuse_a: assert property (mcu_wr_in.valid && mcu_wr_in.data[6:5] == 2'b10 && mcu_control_reg_out[6:5] == 2'b00 |=> !mcu_control_reg_out[6]) else $error("locked write taken");
    dso_hold_a: assert property ($rose(mcu_control_reg_out[6]) |-> dso_held ##1 !mcu_control_reg_out[6]) else $error("sleep-off span wrong");
    standby_wake_a: assert property ($rose(sleep_state_out == ST_STARTUP) && sleep_mode_out == MODE_STANDBY && $past(bod_enable_out) |-> boot_six ##1 sleep_state_out == ST_HALT) else $error("standby wake time wrong");
    prr_a: assert property (!$past(rst_in) |-> periph_access_en_out == ~$past(power_reduction_reg_in)) else $error("access gate wrong");
endmodule
bind smc_sleep_ctrl smc_sleep_ctrl_asserts u_chk (.sys_clk_in, .rst_in, .sleep_instr_in,
    .sleep_ctrl_in, .mcu_wr_in, .power_reduction_reg_in, .clk_en_out, .periph_access_en_out,
    .bod_enable_out, .sleep_state_out, .sleep_mode_out, .mcu_control_reg_out);
`default_nettype wire

// ### tb/smc_sleep_ctrl_test.sv
`default_nettype none
module smc_sleep_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;
    import smc_pkg::*;
    logic clk = 0, rst = 1, instr = 0, crystal = 1, gie = 1, adc_en = 1;
    logic [1:0] fuses = 0, t2_mask = 0;
    logic [7:0] power_reduction_reg = 0, pclk, pacc, mcu_reg;
    smc_sleep_ctrl_t ctrl = '0;
    smc_mcu_wr_t wr_req = '0;
    smc_t2_cfg_t t2 = '0;
    smc_wake_t wake = '0;
    smc_clk_en_t clk_en;
    smc_state_t st;
    smc_mode_t mode;
    logic bod_en, adc_start, wake_ev, halt, wrst;
    int errors = 0, n_checks = 0, cycles = 0, ns, nh;
    smc_mode_t em[8] = '{MODE_IDLE, MODE_ADCNR, MODE_PWR_DOWN, MODE_PWR_SAVE, MODE_IDLE,
        MODE_IDLE, MODE_STANDBY, MODE_EXT_STANDBY};
    logic [7:0] osc = 8'hF3;
    smc_sleep_ctrl u_dut (.sys_clk_in(clk), .rst_in(rst), .sleep_instr_in(instr),
        .sleep_ctrl_in(ctrl), .mcu_wr_in(wr_req), .crystal_clock_in(crystal),
        .clock_select_fuses_in(fuses), .wake_in(wake), .timer_two_irq_mask_in(t2_mask),
        .global_irq_enable_in(gie), .timer2_cfg_in(t2), .adc_enabled_in(adc_en),
        .power_reduction_reg_in(power_reduction_reg), .clk_en_out(clk_en), .periph_clk_en_out(pclk),
        .periph_access_en_out(pacc), .bod_enable_out(bod_en), .adc_start_out(adc_start),
        .cpu_halt_out(halt), .sleep_state_out(st), .sleep_mode_out(mode),
        .wake_event_out(wake_ev), .wake_by_reset_out(wrst), .mcu_control_reg_out(mcu_reg));
    // clock and hang guard
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        if (errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] d);
        wr_req = {1'b1, d};
        cyc(1);
        wr_req.valid = 1'b0;
        cyc(1);
    endtask
    task automatic sleep(input logic [2:0] c, input logic en);
        ctrl = {c, en};
        instr = 1'b1;
        cyc(1);
        instr = 1'b0;
    endtask
    // hold a wake source until seen, then count start-up and halt cycles
    task automatic wake_cnt(input logic [13:0] w);
        wake = w;
        for (int i = 0; i < 20 && wake_ev !== 1'b1; i++) cyc(1);
        wake = '0;
        ns = 0;
        nh = 0;
        while (st == ST_STARTUP) begin ns++; cyc(1); end
        while (st == ST_HALT) begin nh++; cyc(1); end
    endtask
    // main sequence
    initial begin
        cyc(2);
        rst = 0;
        cyc(1);
        check(mcu_reg, 8'h00, "ctrl reset");
        sleep(3'h2, 1'b0);
        cyc(2);
        check(st, ST_ACTIVE, "slept unenabled");
        for (int c = 0; c < 8; c++) begin
            sleep(3'(c), 1'b1);
            check(mode, em[c], "mode decode");
            check(clk_en.io, em[c] == MODE_IDLE, "io clock");
            check(clk_en.main_osc, osc[c], "main osc");
            check(adc_start, em[c] == MODE_IDLE || em[c] == MODE_ADCNR, "adc start");
            check(halt, 1'b1, "cpu halt");
            cyc(1);
            check(bod_en, 1'b1, "detector kept");
            wake_cnt(14'h2000);
            check(16'(nh), 16'h1, "reset halt");
            check(wrst, 1'b1, "reset flag");
        end
        crystal = 0;
        sleep(3'h6, 1'b1);
        check(mode, MODE_IDLE, "no crystal");
        wake_cnt(14'h0001);
        check(16'(nh), 16'h4, "idle irq halt");
        check(wrst, 1'b0, "irq flag");
        crystal = 1;
        sleep(3'h6, 1'b1);
        wake_cnt(14'h0080);
        check(16'(ns), 16'h6, "standby wake");
        fuses = 2'h1;
        sleep(3'h2, 1'b1);
        wake = 14'h0001;
        cyc(3);
        check(st, ST_SLEEP, "pd woke");
        wake_cnt(14'h0200);
        check(16'(ns), 16'h0102, "pd startup");
        fuses = 2'h0;
        power_reduction_reg = 8'h05;
        cyc(2);
        check(pacc, 8'hFA, "access gate");
        check(pclk, 8'hFA, "periph clock");
        sleep(3'h1, 1'b1);
        check(pclk, 8'h00, "adcnr periph clock");
        wake = 14'h0001;
        cyc(3);
        check(st, ST_SLEEP, "adcnr woke");
        wake_cnt(14'h0004);
        check(16'(nh), 16'h4, "adc wake");
        power_reduction_reg = 8'h00;
        cyc(2);
        check(pacc, 8'hFF, "access back");
        t2 = 2'b11;
        sleep(3'h3, 1'b1);
        check(clk_en.timer_osc, 1'b1, "timer osc");
        check(clk_en.main_osc, 1'b0, "ps main osc");
        wake = 14'h0010;
        cyc(3);
        check(st, ST_SLEEP, "unmasked wake");
        t2_mask = 2'h1;
        wake_cnt(14'h0010);
        check(16'(ns), 16'h6, "ps wake");
        t2 = 2'b00;
        wr(8'h40);
        check(mcu_reg, 8'h00, "locked write");
        wr(8'h60);
        cyc(4);
        wr(8'h40);
        check(mcu_reg, 8'h00, "late step");
        wr(8'h60);
        check(mcu_reg[5], 1'b1, "unlock");
        wr(8'h40);
        check(mcu_reg, 8'h40, "sleep-off set");
        cyc(2);
        sleep(3'h2, 1'b1);
        cyc(1);
        check(bod_en, 1'b0, "detector off");
        wake_cnt(14'h0020);
        check(16'(ns), 16'h0960, "long wake");
        check(bod_en, 1'b1, "detector on");
        check(mcu_reg, 8'h00, "sleep-off cleared");
        tally_and_finish();
    end
endmodule
`default_nettype wire
